/* File: hw/bus_cond_detect.sv */
`timescale 1ns/1ps
module bus_cond_detect (
   input wire logic sda_i,
   input wire logic scl_i,
   input wire logic rst_link_b_i,
   output logic start_tog_o,
   output logic stop_tog_o
);

   logic start_tog_reg;
   logic stop_tog_reg;

   // A falling data line while the clock is high marks a start; the edge itself clocks the flag.
   always_ff @(negedge sda_i or negedge rst_link_b_i) begin
      if (!rst_link_b_i) begin
         start_tog_reg <= 1'b0;
      end else if (scl_i) begin
         start_tog_reg <= ~start_tog_reg; // [R13] [R16]
      end
   end

   // A rising data line while the clock is high marks a stop.
   always_ff @(posedge sda_i or negedge rst_link_b_i) begin
      if (!rst_link_b_i) begin
         stop_tog_reg <= 1'b0;
      end else if (scl_i) begin
         stop_tog_reg <= ~stop_tog_reg; // [R16]
      end
   end

   assign start_tog_o = start_tog_reg;
   assign stop_tog_o = stop_tog_reg;

endmodule : bus_cond_detect

/* File: hw/i2c_io_expander_core.sv */
`timescale 1ns/1ps
`include "io_expander_defs.svh"
// Behaviour
// R1: An input pin edge pulls the alert low within 4 us.
// R2: Reading the input port clears the alert at the acknowledge bit.
// R3: The alert withdraws when changed inputs return to their earlier levels.
// R4: A change during the clearing acknowledge pulse may be lost.
// R5: After a clear, every later input change raises the alert again.
// R6: Output pins and traffic to other slaves never touch the alert; here a foreign read acknowledged with pointer 00h clears it (R9).
// R7: Turning an output into an input may raise a false alert.
// R8: The alert pin only pulls low or floats.
// R9: Pointer 00h plus any acknowledged read address clears the alert falsely.
// R10: The master should move the pointer off 00h around reads.
// R11: Reset puts all registers and the serial engine in defaults.
// R12: Input pins have both drivers off; output pins drive their output bit.
// R13: A transfer opens with start, then the address byte MSB first.
// R14: A matching address is acknowledged by holding data low.
// R15: The select pins stay steady from start to stop.
// R16: Data changes only while the clock is low, one bit per pulse.
// R17: The master ends a transfer with a stop.
// R18: Each byte has one acknowledge bit; the sender releases data first.
// R19: As receiver the device acknowledges every byte, any number.
// R20: A master's missing acknowledge makes the device release data.
// R21: The master starts only on an idle bus.
// R22: The first written byte is the register pointer, kept until rewritten.
// R23: The address is four fixed bits and three select pins; LSB is direction.
// R24: A direction bit of 1 makes an input; reset sets all ones.
// R25: A polarity bit of 1 inverts the reported input bit.
// R26: Alert holds while pins differ from levels captured at the last read.
module i2c_io_expander_core (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic [2:0] addr_select_pins_i,
   input wire logic [7:0] port_pins_i,
   output logic [7:0] port_pins_o,
   output logic [7:0] port_pins_oe_o,
   output logic alert_n_o,
   output logic alert_oe_o,
   output io_expander_pkg::port_setup_type setup_o
);
   import io_expander_pkg::*;

   localparam int ALERT_BOUND = `ALERT_VALID_CYC;
   localparam int CLEAR_BOUND = `ALERT_CLEAR_CYC;

   // The serial side resets asynchronously from a registered copy, since its clock stands still when idle.
   logic rst_link_b_reg;
   always_ff @(posedge clk_i) begin
      rst_link_b_reg <= rst_b_i; // [R11]
   end

   logic start_tog;
   logic stop_tog;
   bus_cond_detect u_cond (
      .sda_i(sda_i),
      .scl_i(scl_i),
      .rst_link_b_i(rst_link_b_reg),
      .start_tog_o(start_tog),
      .stop_tog_o(stop_tog)
   );

   // Select pins and port pins enter the serial clock domain through two flops.
   logic [2:0] addr_sel_link;
   logic [7:0] pins_link;
   sync_2ff #(.WIDTH(11)) u_link_sync (
      .clk_i(scl_i),
      .en_i(1'b1),
      .d_i({addr_select_pins_i, port_pins_i}),
      .q_o({addr_sel_link, pins_link})
   );

   link_state_type state_reg;
   logic [2:0] bit_cnt_reg;
   logic [7:0] rx_reg;
   logic [7:0] tx_reg;
   logic [7:0] cmd_reg;
   logic [7:0] invert_reg;
   logic [7:0] read_byte;
   logic match_reg;
   logic rw_reg;
   logic start_seen_reg;
   logic stop_seen_reg;
   logic upd_tog_reg;
   logic clr_tog_reg;
   logic sda_oe_reg;
   logic sda_drive;
   port_setup_type setup_reg;

   // Start and stop arrive as toggles and are consumed at the next rising clock edge.
   logic start_evt;
   logic stop_evt;
   logic last_bit;
   logic addr_hit;
   logic [7:0] rx_byte;
   assign start_evt = start_tog ^ start_seen_reg;
   assign stop_evt = stop_tog ^ stop_seen_reg;
   assign last_bit = bit_cnt_reg == `BIT_LAST;
   assign rx_byte = {rx_reg[6:0], sda_i}; // [R13]
   assign addr_hit = (rx_reg[6:3] == `ADDR_FIXED) && (rx_reg[2:0] == addr_sel_link); // [R23]

   // Condition flags follow the toggles so each start or stop is seen once.
   always_ff @(posedge scl_i or negedge rst_link_b_reg) begin
      if (!rst_link_b_reg) begin
         start_seen_reg <= 1'b0;
         stop_seen_reg <= 1'b0;
      end else begin
         start_seen_reg <= start_tog;
         stop_seen_reg <= stop_tog;
      end
   end

   // Incoming bits shift in MSB first on every rising clock edge.
   always_ff @(posedge scl_i or negedge rst_link_b_reg) begin
      if (!rst_link_b_reg) begin
         rx_reg <= `CMD_RESET;
      end else begin
         rx_reg <= rx_byte; // [R16]
      end
   end

   // The counter runs through data bits and rests at zero during acknowledge bits.
   always_ff @(posedge scl_i or negedge rst_link_b_reg) begin
      if (!rst_link_b_reg) begin
         bit_cnt_reg <= `BIT_ZERO;
      end else if (start_evt) begin
         bit_cnt_reg <= `BIT_FIRST;
      end else if (state_reg inside {ST_ADDR, ST_CMD, ST_WDATA, ST_RDATA}) begin
         bit_cnt_reg <= bit_cnt_reg + `BIT_FIRST; // [R18]
      end else begin
         bit_cnt_reg <= `BIT_ZERO;
      end
   end

   // Address decision is taken on the eighth bit, where the data line carries the direction.
   always_ff @(posedge scl_i or negedge rst_link_b_reg) begin
      if (!rst_link_b_reg) begin
         match_reg <= 1'b0;
         rw_reg <= 1'b0;
      end else if (!start_evt && state_reg == ST_ADDR && last_bit) begin
         match_reg <= addr_hit; // [R23]
         rw_reg <= sda_i;
      end
   end

   // Serial engine; a start wins over everything so a repeated start always realigns.
   always_ff @(posedge scl_i or negedge rst_link_b_reg) begin
      if (!rst_link_b_reg) begin
         state_reg <= ST_IDLE; // [R11]
      end else if (start_evt) begin
         state_reg <= ST_ADDR; // [R13]
      end else if (stop_evt) begin
         state_reg <= ST_IDLE; // [R17]
      end else begin
         unique case (state_reg)
            ST_IDLE: state_reg <= ST_IDLE;
            ST_ADDR: begin
               if (last_bit) begin
                  state_reg <= ST_ADDR_ACK;
               end
            end
            ST_ADDR_ACK: begin
               // Foreign addresses still pass through here so their read acknowledges are seen.
               if (!match_reg) begin
                  state_reg <= ST_IDLE; // [R6]
               end else if (rw_reg) begin
                  state_reg <= ST_RDATA;
               end else begin
                  state_reg <= ST_CMD;
               end
            end
            ST_CMD: begin
               if (last_bit) begin
                  state_reg <= ST_CMD_ACK;
               end
            end
            ST_CMD_ACK: state_reg <= ST_WDATA;
            ST_WDATA: begin
               if (last_bit) begin
                  state_reg <= ST_WACK;
               end
            end
            ST_WACK: state_reg <= ST_WDATA; // [R19]
            ST_RDATA: begin
               if (last_bit) begin
                  state_reg <= ST_RACK;
               end
            end
            ST_RACK: state_reg <= sda_i ? ST_IDLE : ST_RDATA; // [R20]
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // The command byte and the register writes that follow it.
   always_ff @(posedge scl_i or negedge rst_link_b_reg) begin
      if (!rst_link_b_reg) begin
         cmd_reg <= `CMD_RESET;
         invert_reg <= `INVERT_RESET;
         setup_reg.drive <= `DRIVE_RESET;
         setup_reg.dir <= `DIR_RESET; // [R24]
         upd_tog_reg <= 1'b0;
      end else if (!start_evt && state_reg == ST_CMD && last_bit) begin
         cmd_reg <= rx_byte; // [R22]
      end else if (!start_evt && state_reg == ST_WDATA && last_bit) begin
         // Writes to the input port have no effect.
         unique case (cmd_reg[1:0])
            `CMD_INPUT: ;
            `CMD_OUTPUT: begin
               setup_reg.drive <= rx_byte;
               upd_tog_reg <= ~upd_tog_reg;
            end
            `CMD_INVERT: invert_reg <= rx_byte;
            `CMD_CONFIG: begin
               setup_reg.dir <= rx_byte; // [R24]
               upd_tog_reg <= ~upd_tog_reg;
            end
         endcase
      end
   end

   // Read value of the register chosen by the pointer.
   always_comb begin
      unique case (cmd_reg[1:0])
         `CMD_INPUT: read_byte = pins_link ^ invert_reg; // [R25]
         `CMD_OUTPUT: read_byte = setup_reg.drive;
         `CMD_INVERT: read_byte = invert_reg;
         `CMD_CONFIG: read_byte = setup_reg.dir;
      endcase
   end

   // Transmit shifter: loaded after an address or a master acknowledge, shifted after each bit.
   always_ff @(posedge scl_i or negedge rst_link_b_reg) begin
      if (!rst_link_b_reg) begin
         tx_reg <= `CMD_RESET;
      end else if (state_reg == ST_ADDR_ACK && match_reg && rw_reg) begin
         tx_reg <= read_byte; // [R22]
      end else if (state_reg == ST_RACK && !sda_i) begin
         tx_reg <= read_byte;
      end else if (state_reg == ST_RDATA) begin
         tx_reg <= {tx_reg[6:0], 1'b0};
      end
   end

   // Clear event toward the pin side; the clear falls inside the acknowledge pulse, so a change then may be lost.
   logic clr_own;
   logic clr_false;
   assign clr_own = !start_evt && state_reg == ST_RACK && cmd_reg[1:0] == `CMD_INPUT; // [R2] [R4]
   assign clr_false = !start_evt && state_reg == ST_ADDR_ACK && rw_reg && !sda_i && cmd_reg == `CMD_ERRATA; // [R9]
   always_ff @(posedge scl_i or negedge rst_link_b_reg) begin
      if (!rst_link_b_reg) begin
         clr_tog_reg <= 1'b0;
      end else if (clr_own || clr_false) begin
         clr_tog_reg <= ~clr_tog_reg;
      end
   end

   // The data line changes only on the falling clock edge, so it is stable while the clock is high.
   always_comb begin
      sda_drive = (state_reg == ST_ADDR_ACK && match_reg) // [R14]
         || state_reg == ST_CMD_ACK
         || state_reg == ST_WACK // [R19]
         || (state_reg == ST_RDATA && !tx_reg[7]); // [R18] [R20]
   end

   always_ff @(negedge scl_i or negedge rst_link_b_reg) begin
      if (!rst_link_b_reg) begin
         sda_oe_reg <= 1'b0;
      end else begin
         sda_oe_reg <= sda_drive; // [R16]
      end
   end

   assign sda_o = 1'b0;
   assign sda_oe_o = sda_oe_reg;

   // Pin side: toggles and port pins cross into the system clock through two flops.
   logic upd_sync;
   logic clr_sync;
   logic [7:0] pins_sys;
   sync_2ff #(.WIDTH(10)) u_sys_sync (
      .clk_i(clk_i),
      .en_i(ce_i),
      .d_i({upd_tog_reg, clr_tog_reg, port_pins_i}),
      .q_o({upd_sync, clr_sync, pins_sys})
   );

   logic upd_seen_reg;
   logic clr_seen_reg;
   logic [7:0] snap_reg;
   logic alert_reg;
   port_setup_type setup_sys_reg;
   logic upd_evt;
   logic clr_evt;
   logic [7:0] diff;
   assign upd_evt = upd_sync ^ upd_seen_reg;
   assign clr_evt = clr_sync ^ clr_seen_reg;

   // The setup word is stable for a whole byte after its toggle, so it is copied once the toggle lands.
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         upd_seen_reg <= 1'b0;
         setup_sys_reg.drive <= `DRIVE_RESET;
         setup_sys_reg.dir <= `DIR_RESET; // [R11] [R24]
      end else if (ce_i) begin
         upd_seen_reg <= upd_sync;
         if (upd_evt) begin
            setup_sys_reg <= setup_reg;
         end
      end
   end

   // Reference levels are taken at reset and at every clear.
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         clr_seen_reg <= 1'b0;
         snap_reg <= pins_sys;
      end else if (ce_i) begin
         clr_seen_reg <= clr_sync;
         if (clr_evt) begin
            snap_reg <= pins_sys; // [R2] [R5]
         end
      end
   end

   // Only input pins compare; a pin just turned to input may differ at once and raise a false alert.
   assign diff = (pins_sys ^ snap_reg) & setup_sys_reg.dir; // [R6] [R7] [R26]

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         alert_reg <= 1'b0;
      end else if (ce_i) begin
         alert_reg <= |diff; // [R1] [R3] [R5]
      end
   end

   // The alert pin is open drain: it only ever pulls low.
   assign alert_n_o = 1'b0; // [R8]
   assign alert_oe_o = alert_reg; // [R8]
   assign port_pins_o = setup_sys_reg.drive; // [R12]
   assign port_pins_oe_o = ~setup_sys_reg.dir; // [R12]
   assign setup_o = setup_sys_reg;

   // Checks on the pin side.
   a_alert_valid: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R1]
      ce_i && (|diff) |-> ##[0:ALERT_BOUND] alert_reg)
      else $error("alert not raised after an input change");
   a_alert_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R2]
      ce_i && clr_evt ##1 ce_i |-> snap_reg == $past(pins_sys))
      else $error("clear did not capture the pin levels");
   a_alert_withdraw: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R3]
      ce_i && !(|diff) |=> !alert_reg)
      else $error("alert held with no pending difference");
   a_output_quiet: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R6]
      ce_i && setup_sys_reg.dir == 8'h00 |=> !alert_reg)
      else $error("output pins raised the alert");
   a_drive_follow: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R12]
      ce_i && upd_evt |=> port_pins_o == $past(setup_reg.drive) && port_pins_oe_o == ~$past(setup_reg.dir))
      else $error("pin drive did not follow the setup");
   a_reset_default: assert property (@(posedge clk_i) // [R11]
      !rst_b_i |=> port_pins_oe_o == 8'h00 && !alert_oe_o)
      else $error("reset defaults not applied");
   a_clear_delay: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R2]
      $changed(clr_tog_reg) && !(|((port_pins_i ^ pins_sys))) |-> ##[1:CLEAR_BOUND] clr_evt)
      else $error("clear did not reach the pin side in time");

   // Checks on the serial side.
   a_ack_address: assert property (@(posedge scl_i) disable iff (!rst_link_b_reg) // [R14]
      state_reg == ST_ADDR_ACK && match_reg |-> sda_oe_reg)
      else $error("matching address not acknowledged");
   a_ack_write: assert property (@(posedge scl_i) disable iff (!rst_link_b_reg) // [R19]
      state_reg inside {ST_CMD_ACK, ST_WACK} |-> sda_oe_reg)
      else $error("received byte not acknowledged");
   a_release_ack: assert property (@(posedge scl_i) disable iff (!rst_link_b_reg) // [R18]
      state_reg inside {ST_RACK, ST_ADDR, ST_CMD, ST_WDATA} |-> !sda_oe_reg)
      else $error("data line held while the other party owns it");
   a_nack_release: assert property (@(posedge scl_i) disable iff (!rst_link_b_reg) // [R20]
      state_reg == ST_RACK && sda_i && !start_evt && !stop_evt |=> state_reg == ST_IDLE && !sda_oe_reg)
      else $error("device kept the line after a missing acknowledge");
   a_false_clear: assert property (@(posedge scl_i) disable iff (!rst_link_b_reg) // [R9]
      clr_false |=> clr_tog_reg != $past(clr_tog_reg))
      else $error("foreign read acknowledge did not clear");
   a_pointer_keep: assert property (@(posedge scl_i) disable iff (!rst_link_b_reg) // [R22]
      state_reg == ST_CMD_ACK |-> cmd_reg == $past(rx_byte))
      else $error("command byte not stored");

   c_port_read: cover property (@(posedge scl_i) disable iff (!rst_link_b_reg) clr_own);
   c_config_write: cover property (@(posedge clk_i) disable iff (!rst_b_i) upd_evt);
   c_alert_cycle: cover property (@(posedge clk_i) disable iff (!rst_b_i) alert_reg ##[1:1000] !alert_reg);
   c_false_clear: cover property (@(posedge scl_i) disable iff (!rst_link_b_reg) clr_false && !match_reg);

endmodule : i2c_io_expander_core

/* File: hw/io_expander_defs.svh */
`ifndef IO_EXPANDER_DEFS_SVH
`define IO_EXPANDER_DEFS_SVH

// Upper four bits of the seven-bit slave address; the low three come from the select pins.
`define ADDR_FIXED 4'h4

// Register selection held in the low two bits of the stored command byte.
`define CMD_INPUT 2'h0
`define CMD_OUTPUT 2'h1
`define CMD_INVERT 2'h2
`define CMD_CONFIG 2'h3

// Command byte value that exposes the false clear on foreign reads.
`define CMD_ERRATA 8'h00
`define CMD_RESET 8'h00

// Register defaults after reset.
`define DRIVE_RESET 8'hFF
`define INVERT_RESET 8'h00
`define DIR_RESET 8'hFF

// Bit counter positions within a byte.
`define BIT_ZERO 3'h0
`define BIT_FIRST 3'h1
`define BIT_LAST 3'h7

// System clock rate and alert timing.
`define CLK_MHZ 100
`define ALERT_VALID_US 4
`define ALERT_VALID_CYC (`ALERT_VALID_US * `CLK_MHZ)
`define ALERT_CLEAR_US 4
`define ALERT_CLEAR_CYC (`ALERT_CLEAR_US * `CLK_MHZ)

`endif

/* File: hw/io_expander_pkg.sv */
package io_expander_pkg;

   // Serial engine states, one bit changing along each forward step from idle through bytes and acknowledges.
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_ADDR = 4'h1,
      ST_ADDR_ACK = 4'h3,
      ST_CMD = 4'h2,
      ST_CMD_ACK = 4'h6,
      ST_WDATA = 4'h7,
      ST_WACK = 4'h5,
      ST_RDATA = 4'hB,
      ST_RACK = 4'h9
   } link_state_type;

   // Pin setup that travels from the serial side to the pin side as one unit.
   typedef struct packed {
      logic [7:0] drive;
      logic [7:0] dir;
   } port_setup_type;

endpackage : io_expander_pkg

/* File: hw/sync_2ff.sv */
`timescale 1ns/1ps
module sync_2ff #(
   parameter int WIDTH = 1
) (
   input wire logic clk_i,
   input wire logic en_i,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   // Each bit is synchronised on its own; only independent bits or toggles may pass here.
   always_ff @(posedge clk_i) begin
      if (en_i) begin
         meta_reg <= d_i;
         sync_reg <= meta_reg;
      end
   end

   assign q_o = sync_reg;

endmodule : sync_2ff

/* File: sim/i2c_master_model.sv */
`timescale 1ns/1ps
module i2c_master_model (
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_pull_o,
   output logic [7:0] rd_data_o,
   output logic rd_stb_o
);
   // The bus clock stands high between frames and only toggles inside one.
   initial begin
      scl_o = 1'b1;
      sda_pull_o = 1'b0;
      rd_data_o = 8'h00;
      rd_stb_o = 1'b0;
   end
   // One bit per clock pulse; data moves mid low phase and is sampled while high.
   task automatic bit_io(input logic b, output logic s);
      #20;
      sda_pull_o = ~b;
      #20;
      scl_o = 1'b1;
      #20;
      s = sda_i;
      #20;
      scl_o = 1'b0;
   endtask : bit_io
   // Start or repeated start, only from an idle bus or our own frame.
   task automatic start_cond();
      #20;
      sda_pull_o = 1'b0;
      #20;
      scl_o = 1'b1;
      #20;
      sda_pull_o = 1'b1;
      #20;
      scl_o = 1'b0;
   endtask : start_cond
   // Stop: data rises while the clock is high, leaving the bus idle.
   task automatic stop_cond();
      #20;
      sda_pull_o = 1'b1;
      #20;
      scl_o = 1'b1;
      #20;
      sda_pull_o = 1'b0;
      #20;
   endtask : stop_cond
   // Byte out MSB first; the ninth bit is released unless a foreign slave is mimicked.
   task automatic wbyte(input logic [7:0] d, input logic other_ack, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(d[i], s);
      bit_io(~other_ack, ack);
   endtask : wbyte
   // Byte in, closed with no acknowledge so the slave lets go of data.
   task automatic rbyte();
      logic [7:0] d;
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(1'b1, s);
      rd_data_o = d;
      rd_stb_o = 1'b1;
      #1;
      rd_stb_o = 1'b0;
   endtask : rbyte
endmodule : i2c_master_model

/* File: sim/tb.sv */
`timescale 1ns/1ps
`include "io_expander_defs.svh"
module tb;
   import io_expander_pkg::*;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [2:0] sel = 3'h5; // Select pins stay put for the whole run.
   logic ce = 1'b1;
   port_setup_type setup;
   logic [7:0] ext = 8'hFF;
   logic [7:0] lfsr = 8'h20;
   logic [7:0] pins_out, pins_oe, pins, old, rd_data;
   logic sda_oe, m_pull, scl, sda, alert_oe, alert_n, sda_o, rd_stb, ack;
   logic [6:0] adr;
   logic [7:0] q[$];
   int bad_count = 0;
   int n_checks = 0;

   // The data line has a pull-up, so a released line reads high.
   assign sda = ~(sda_oe | m_pull);
   assign pins = (pins_oe & pins_out) | (~pins_oe & ext);

   i2c_io_expander_core DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe_o(sda_oe), .addr_select_pins_i(sel), .port_pins_i(pins),
      .port_pins_o(pins_out), .port_pins_oe_o(pins_oe), .alert_n_o(alert_n), .alert_oe_o(alert_oe),
      .setup_o(setup));
   i2c_master_model m (.sda_i(sda), .scl_o(scl), .sda_pull_o(m_pull), .rd_data_o(rd_data), .rd_stb_o(rd_stb));

   // System clock, 100 MHz.
   initial begin
      forever #5 clk_i = ~clk_i;
   end

   function automatic logic [7:0] next_lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : next_lfsr

   task automatic check1(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH at %0t: bit %b, expected %b", $time, got, exp);
      end
   endtask : check1

   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH at %0t: byte %h, expected %h", $time, got, exp);
      end
   endtask : check8

   task automatic conclude();
      $display("checks %0d, mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : conclude

   // Write transfer: pointer byte, then up to two data bytes in the same frame.
   task automatic wr(input logic [7:0] cmd, input int n, input logic [7:0] d0, input logic [7:0] d1);
      m.start_cond();
      m.wbyte({adr, 1'b0}, 1'b0, ack);
      check1(ack, 1'b0);
      m.wbyte(cmd, 1'b0, ack);
      check1(ack, 1'b0);
      for (int i = 0; i < n; i++) begin
         m.wbyte(i == 0 ? d0 : d1, 1'b0, ack);
         check1(ack, 1'b0);
      end
      m.stop_cond();
   endtask : wr

   // Read transfer of one byte; the expectation is queued for the watcher.
   task automatic rd(input logic [7:0] exp);
      m.start_cond();
      m.wbyte({adr, 1'b1}, 1'b0, ack);
      check1(ack, 1'b0);
      q.push_back(exp);
      m.rbyte();
      m.stop_cond();
   endtask : rd

   // Read addressed to another slave, which answers only when asked to.
   task automatic foreign(input logic oack);
      m.start_cond();
      m.wbyte({adr ^ 7'h01, 1'b1}, oack, ack);
      check1(ack, ~oack);
      m.stop_cond();
   endtask : foreign

   task automatic set_pins(input logic [7:0] v);
      @(posedge clk_i);
      ext <= v;
      @(posedge clk_i);
   endtask : set_pins

   // Bounded wait: the alert must settle within its valid time; it is looked at mid cycle, where it is settled.
   task automatic wait_alert(input logic exp);
      for (int i = 0; i < `ALERT_VALID_CYC && alert_oe !== exp; i++) @(negedge clk_i);
      check1(alert_oe, exp);
   endtask : wait_alert

   // Watcher: every byte the master reads is matched against the oldest note.
   initial begin
      forever begin
         @(posedge rd_stb);
         check8(rd_data, q.pop_front());
      end
   end

   // Watchdog sized well above the roughly seventeen microseconds the tests need.
   initial begin
      #200_000;
      bad_count++;
      conclude();
   end

   initial begin
      repeat (5) @(posedge clk_i);
      rst_b_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      adr = {`ADDR_FIXED, sel};
      check8(pins_oe, 8'h00);
      check1(alert_oe, 1'b0);
      check1(alert_n, 1'b0);
      $display("test reset done");
      wr(8'h03, 1, 8'h0F, 8'h00);
      wr(8'h01, 2, 8'h5A, 8'hA5);
      repeat (10) @(posedge clk_i);
      check8(pins_oe, 8'hF0);
      check8(pins_out & 8'hF0, 8'hA0);
      check8(setup.dir, 8'h0F);
      check8(setup.drive, 8'hA5);
      check1(alert_oe, 1'b0);
      check1(sda_o, 1'b0);
      $display("test direction done");
      wr(8'h02, 1, 8'h03, 8'h00);
      old = ext;
      lfsr = next_lfsr(lfsr);
      // A pin change while the enable is low is held back until the enable returns.
      @(posedge clk_i);
      ce <= 1'b0;
      set_pins(ext ^ {4'h0, lfsr[3:0] | 4'h1});
      repeat (10) @(negedge clk_i);
      check1(alert_oe, 1'b0);
      @(posedge clk_i);
      ce <= 1'b1;
      wait_alert(1'b1);
      set_pins(old);
      wait_alert(1'b0);
      lfsr = next_lfsr(lfsr);
      set_pins(ext ^ {4'h0, lfsr[3:0] | 4'h2});
      wait_alert(1'b1);
      wr(8'h00, 0, 8'h00, 8'h00);
      rd({4'hA, ext[3:0]} ^ 8'h03);
      wait_alert(1'b0);
      set_pins(ext ^ 8'h02);
      wait_alert(1'b1);
      $display("test alert done");
      foreign(1'b0);
      repeat (50) @(posedge clk_i);
      check1(alert_oe, 1'b1);
      foreign(1'b1);
      wait_alert(1'b0);
      set_pins(ext ^ 8'h04);
      wait_alert(1'b1);
      wr(8'h01, 0, 8'h00, 8'h00);
      foreign(1'b1);
      repeat (50) @(posedge clk_i);
      check1(alert_oe, 1'b1);
      $display("test foreign done");
      conclude();
   end
endmodule : tb
